// >>> design/tcc_defs.vh
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// =====================================================
// Clock rates in kHz
`define TCC_SYS_KHZ 14'h2710
`define TCC_CCLK8_KHZ 14'h0fa0
`define TCC_CCLK12_KHZ 14'h07d0

// =====================================================
// Conversion sequence
`define TCC_SAMPLE_TICKS 2'h3
`define TCC_FILT_LAST 3'h6
`define TCC_MSB_IDX 4'hb
`define TCC_LSB8_IDX 4'h4
`define TCC_LSB12_IDX 4'h0
`define TCC_CODE_MID 12'h800
`define TCC_DIV3_MUL 16'haaab

// =====================================================
// Channel codes
`define TCC_CH_X 3'h0
`define TCC_CH_Y 3'h1
`define TCC_CH_Z1 3'h2
`define TCC_CH_Z2 3'h3
`define TCC_CH_TEMP_SINGLE 3'h4
`define TCC_CH_TEMP_RATIO 3'h5
`define TCC_CH_AUX 3'h6

// =====================================================
// Multiplexer input codes
`define TCC_MUX_XP 3'h0
`define TCC_MUX_YP 3'h1
`define TCC_MUX_YN 3'h2
`define TCC_MUX_TEMP_SINGLE 3'h3
`define TCC_MUX_TEMP_RATIO 3'h4
`define TCC_MUX_AUX 3'h5
`define TCC_MUX_NONE 3'h7

// =====================================================
// Reference codes
`define TCC_REF_SUPPLY 2'h0
`define TCC_REF_XPLATE 2'h1
`define TCC_REF_YPLATE 2'h2
`define TCC_REF_CROSS 2'h3

`endif

// >>> design/tcc_clkdiv.v
`timescale 1ns/10ps
`include "tcc_defs.vh"

module tcc_clkdiv #(
  parameter [13:0] SYS_KHZ = `TCC_SYS_KHZ,
  parameter [13:0] FAST_KHZ = `TCC_CCLK8_KHZ,
  parameter [13:0] SLOW_KHZ = `TCC_CCLK12_KHZ
) (
  input wire clk,
  input wire nrst,
  input wire mode8,
  output reg tick_ff
);

  reg [13:0] acc_ff;
  wire [13:0] inc;
  wire [14:0] sum;
  wire [14:0] wrap;
  reg [13:0] nxt_acc;
  reg nxt_tick;

  // =====================================================
  // Fractional divider of the internal clock
  assign inc = mode8 ? FAST_KHZ : SLOW_KHZ;
  assign sum = {1'b0, acc_ff} + {1'b0, inc};
  assign wrap = sum - {1'b0, SYS_KHZ};

  always @* begin
    if (sum >= {1'b0, SYS_KHZ}) begin
      nxt_acc = wrap[13:0];
      nxt_tick = 1'b1;
    end else begin
      nxt_acc = sum[13:0];
      nxt_tick = 1'b0;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_ff <= 14'h0000;
      tick_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end

endmodule

// >>> design/tcc_ctrl.v
`timescale 1ns/10ps
`include "tcc_defs.vh"

module tcc_ctrl (
  input wire CLK,
  input wire NRST,
  input wire CMD_VALID,
  input wire [2:0] CMD_CHAN,
  input wire CMD_DRV_ONLY,
  input wire CMD_MODE8,
  input wire CMD_FILT_BYPASS,
  input wire RESULT_READ,
  input wire COMP_IN,
  output reg BUSY,
  output reg [11:0] RESULT,
  output reg RESULT_VALID,
  output reg RESULT_8BIT,
  output reg [2:0] MUX_SEL,
  output reg [1:0] REF_SEL,
  output reg DRV_XP,
  output reg DRV_XN,
  output reg DRV_YP,
  output reg DRV_YN,
  output reg SAMPLE,
  output reg [11:0] DAC_CODE
);

  // =====================================================
  // States
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SAMP = 5'h02;
  localparam [4:0] ST_CONV = 5'h04;
  localparam [4:0] ST_SORT = 5'h08;
  localparam [4:0] ST_AVG = 5'h10;

  reg [4:0] state_ff;
  reg mode8_ff;
  reg bypass_ff;
  reg comp_lat_ff;
  reg [1:0] samp_cnt_ff;
  reg [3:0] bit_idx_ff;
  reg [2:0] filt_cnt_ff;
  reg [2:0] pass_ff;
  reg [11:0] samp_ff [0:6];
  wire cclk_tick;

  // =====================================================
  // Converter clock
  tcc_clkdiv u_clkdiv (
    .clk(CLK),
    .nrst(NRST),
    .mode8(mode8_ff),
    .tick_ff(cclk_tick)
  );

  // =====================================================
  // Comparator latch
  // Comparator settles on DAC_CODE within one cycle
  // Two stages would miss the 2-cycle tick gaps of 8-bit mode
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      comp_lat_ff <= 1'b0;
    end else begin
      comp_lat_ff <= COMP_IN;
    end
  end

  // =====================================================
  // Channel decode into drivers, mux and reference
  reg [2:0] nxt_mux;
  reg [1:0] nxt_ref;
  reg [3:0] nxt_drv;

  always @* begin
    nxt_mux = `TCC_MUX_NONE;
    nxt_ref = `TCC_REF_SUPPLY;
    nxt_drv = 4'h0;
    case (CMD_CHAN)
      `TCC_CH_X: begin
        nxt_mux = `TCC_MUX_YP;
        nxt_ref = `TCC_REF_XPLATE;
        nxt_drv = 4'hc;
      end
      `TCC_CH_Y: begin
        nxt_mux = `TCC_MUX_XP;
        nxt_ref = `TCC_REF_YPLATE;
        nxt_drv = 4'h3;
      end
      `TCC_CH_Z1: begin
        nxt_mux = `TCC_MUX_XP;
        nxt_ref = `TCC_REF_CROSS;
        nxt_drv = 4'h6;
      end
      `TCC_CH_Z2: begin
        nxt_mux = `TCC_MUX_YN;
        nxt_ref = `TCC_REF_CROSS;
        nxt_drv = 4'h6;
      end
      `TCC_CH_TEMP_SINGLE: begin
        nxt_mux = `TCC_MUX_TEMP_SINGLE;
      end
      `TCC_CH_TEMP_RATIO: begin
        nxt_mux = `TCC_MUX_TEMP_RATIO;
      end
      `TCC_CH_AUX: begin
        nxt_mux = `TCC_MUX_AUX;
      end
      default: begin
        nxt_mux = `TCC_MUX_NONE;
      end
    endcase
  end

  // =====================================================
  // Bit decision
  reg [11:0] nxt_code;
  reg [11:0] nxt_value;
  wire [3:0] last_idx;
  wire last_bit;
  wire [3:0] lower_idx;

  assign last_idx = mode8_ff ? `TCC_LSB8_IDX : `TCC_LSB12_IDX;
  assign last_bit = (bit_idx_ff == last_idx);
  assign lower_idx = bit_idx_ff - 4'h1;

  always @* begin
    nxt_code = DAC_CODE;
    nxt_code[bit_idx_ff] = comp_lat_ff;
    if (!last_bit) begin
      nxt_code[lower_idx] = 1'b1;
    end
    if (mode8_ff) begin
      nxt_value = {4'h0, nxt_code[11:4]};
    end else begin
      nxt_value = nxt_code;
    end
  end

  // =====================================================
  // Sorting pass and middle average
  reg [11:0] srt [0:6];
  reg [11:0] swap_tmp;
  reg [13:0] mid_sum;
  reg [29:0] mid_prod;
  integer i;
  integer j;

  always @* begin
    swap_tmp = 12'h000;
    for (i = 0; i < 7; i = i + 1) begin
      srt[i] = samp_ff[i];
    end
    for (i = 0; i < 6; i = i + 1) begin
      if ((i % 2) == pass_ff[0] && srt[i] > srt[i + 1]) begin
        swap_tmp = srt[i];
        srt[i] = srt[i + 1];
        srt[i + 1] = swap_tmp;
      end
    end
    mid_sum = {2'h0, samp_ff[2]} + {2'h0, samp_ff[3]} +
      {2'h0, samp_ff[4]};
    mid_prod = mid_sum * `TCC_DIV3_MUL;
  end

  // =====================================================
  // Sequencer
  wire take_cmd;
  wire conv_end;
  wire filt_end;
  reg done;
  reg [11:0] nxt_result;

  assign take_cmd = CMD_VALID && state_ff == ST_IDLE;
  assign conv_end = state_ff == ST_CONV && cclk_tick && last_bit;
  assign filt_end = state_ff == ST_AVG;

  always @* begin
    done = 1'b0;
    nxt_result = RESULT;
    if (conv_end && bypass_ff) begin
      done = 1'b1;
      nxt_result = nxt_value;
    end else if (filt_end) begin
      done = 1'b1;
      nxt_result = mid_prod[28:17];
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_ff <= ST_IDLE;
      mode8_ff <= 1'b0;
      bypass_ff <= 1'b0;
      samp_cnt_ff <= 2'h0;
      bit_idx_ff <= `TCC_MSB_IDX;
      filt_cnt_ff <= 3'h0;
      pass_ff <= 3'h0;
      BUSY <= 1'b0;
      SAMPLE <= 1'b0;
      DAC_CODE <= 12'h000;
      MUX_SEL <= `TCC_MUX_NONE;
      REF_SEL <= `TCC_REF_SUPPLY;
      DRV_XP <= 1'b0;
      DRV_XN <= 1'b0;
      DRV_YP <= 1'b0;
      DRV_YN <= 1'b0;
      RESULT <= 12'h000;
      RESULT_8BIT <= 1'b0;
      for (j = 0; j < 7; j = j + 1) begin
        samp_ff[j] <= 12'h000;
      end
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (take_cmd) begin
            // Selection is only changed between conversions
            MUX_SEL <= nxt_mux;
            REF_SEL <= nxt_ref;
            DRV_XP <= nxt_drv[3];
            DRV_XN <= nxt_drv[2];
            DRV_YP <= nxt_drv[1];
            DRV_YN <= nxt_drv[0];
            mode8_ff <= CMD_MODE8;
            bypass_ff <= CMD_FILT_BYPASS;
            filt_cnt_ff <= 3'h0;
            if (!CMD_DRV_ONLY) begin
              state_ff <= ST_SAMP;
              BUSY <= 1'b1;
              samp_cnt_ff <= 2'h0;
            end
          end
        end
        ST_SAMP: begin
          SAMPLE <= 1'b1;
          if (cclk_tick) begin
            samp_cnt_ff <= samp_cnt_ff + 2'h1;
            if (samp_cnt_ff == `TCC_SAMPLE_TICKS - 2'h1) begin
              SAMPLE <= 1'b0;
              DAC_CODE <= `TCC_CODE_MID;
              bit_idx_ff <= `TCC_MSB_IDX;
              state_ff <= ST_CONV;
            end
          end
        end
        ST_CONV: begin
          if (cclk_tick) begin
            DAC_CODE <= nxt_code;
            bit_idx_ff <= lower_idx;
            if (last_bit) begin
              samp_ff[filt_cnt_ff] <= nxt_value;
              filt_cnt_ff <= filt_cnt_ff + 3'h1;
              samp_cnt_ff <= 2'h0;
              if (bypass_ff) begin
                state_ff <= ST_IDLE;
              end else if (filt_cnt_ff == `TCC_FILT_LAST) begin
                pass_ff <= 3'h0;
                state_ff <= ST_SORT;
              end else begin
                state_ff <= ST_SAMP;
              end
            end
          end
        end
        ST_SORT: begin
          for (j = 0; j < 7; j = j + 1) begin
            samp_ff[j] <= srt[j];
          end
          pass_ff <= pass_ff + 3'h1;
          if (pass_ff == `TCC_FILT_LAST) begin
            state_ff <= ST_AVG;
          end
        end
        ST_AVG: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      if (done) begin
        RESULT <= nxt_result;
        RESULT_8BIT <= mode8_ff;
        BUSY <= 1'b0;
        DRV_XP <= 1'b0;
        DRV_XN <= 1'b0;
        DRV_YP <= 1'b0;
        DRV_YN <= 1'b0;
      end
    end
  end

  // =====================================================
  // Result flag, completion wins over read
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RESULT_VALID <= 1'b0;
    end else if (done) begin
      RESULT_VALID <= 1'b1;
    end else if (RESULT_READ) begin
      RESULT_VALID <= 1'b0;
    end
  end

endmodule

// >>> testbench/tcc_chk.sv
`timescale 1ns/10ps
// ==========================================
// Port checker
module tcc_chk (
  input logic CLK,
  input logic NRST,
  input logic CMD_VALID,
  input logic [2:0] CMD_CHAN,
  input logic CMD_DRV_ONLY,
  input logic CMD_MODE8,
  input logic CMD_FILT_BYPASS,
  input logic RESULT_READ,
  input logic BUSY,
  input logic [11:0] RESULT,
  input logic RESULT_VALID,
  input logic RESULT_8BIT,
  input logic [2:0] MUX_SEL,
  input logic [1:0] REF_SEL,
  input logic DRV_XP,
  input logic DRV_XN,
  input logic DRV_YP,
  input logic DRV_YN,
  input logic SAMPLE
);
  logic bz_ff;
  logic m8_ff;
  logic byp_ff;
  logic [9:0] cnt_ff;
  logic take;
  assign take = CMD_VALID && !BUSY && !bz_ff;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bz_ff <= 1'b0;
      m8_ff <= 1'b0;
      byp_ff <= 1'b0;
      cnt_ff <= 10'h000;
    end else begin
      bz_ff <= BUSY;
      cnt_ff <= BUSY ? cnt_ff + 10'h001 : 10'h000;
      if (take && !CMD_DRV_ONLY) begin
        m8_ff <= CMD_MODE8;
        byp_ff <= CMD_FILT_BYPASS;
      end
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_conv_take;
    take && !CMD_DRV_ONLY;
  endsequence
  sequence s_acquire;
    BUSY ##1 SAMPLE;
  endsequence
  property p_y_drv;
    take && CMD_CHAN == 3'h1 |=> MUX_SEL == 3'h0 && REF_SEL == 2'h2
      && DRV_YP && DRV_YN && !DRV_XP && !DRV_XN;
  endproperty
  a_y_drv: assert property (p_y_drv) else $error("y drive wrong");
  property p_x_ref;
    take && CMD_CHAN == 3'h0 |=> MUX_SEL == 3'h1 && REF_SEL == 2'h1
      && DRV_XP && DRV_XN;
  endproperty
  a_x_ref: assert property (p_x_ref) else $error("x ref wrong");
  property p_drv_only;
    take && CMD_DRV_ONLY |=> !BUSY [*8];
  endproperty
  a_drv_only: assert property (p_drv_only) else $error("busy");
  property p_hold;
    BUSY && bz_ff |-> $stable(MUX_SEL)
      && $stable({REF_SEL, DRV_XP, DRV_XN, DRV_YP, DRV_YN});
  endproperty
  a_hold: assert property (p_hold) else $error("input moved");
  property p_start;
    s_conv_take |=> s_acquire;
  endproperty
  a_start: assert property (p_start) else $error("no sample");
  property p_len;
    $fell(BUSY) && byp_ff |-> (m8_ff ? (cnt_ff >= 10'd24 && cnt_ff <= 10'd33)
      : (cnt_ff >= 10'd70 && cnt_ff <= 10'd82));
  endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_mode;
    $fell(BUSY) |-> RESULT_VALID && RESULT_8BIT == m8_ff;
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_byte;
    RESULT_8BIT |-> RESULT[11:8] == 4'h0;
  endproperty
  a_byte: assert property (p_byte) else $error("upper bits set");
  property p_res_hold;
    !$fell(BUSY) |-> $stable(RESULT);
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("moved");
  property p_read;
    RESULT_READ && !BUSY |=> !RESULT_VALID;
  endproperty
  a_read: assert property (p_read) else $error("valid kept");
endmodule

bind tcc_ctrl tcc_chk u_chk (.CLK, .NRST, .CMD_VALID, .CMD_CHAN,
  .CMD_DRV_ONLY, .CMD_MODE8, .CMD_FILT_BYPASS, .RESULT_READ, .BUSY,
  .RESULT, .RESULT_VALID, .RESULT_8BIT, .MUX_SEL, .REF_SEL, .DRV_XP,
  .DRV_XN, .DRV_YP, .DRV_YN, .SAMPLE);

// >>> testbench/tcc_afe.sv
`timescale 1ns/10ps
// ==========================================
// Analog front end and comparator
module tcc_afe (
  input logic CLK,
  input logic [2:0] mux_sel,
  input logic [11:0] dac_code,
  input logic sample,
  output logic comp
);
  localparam logic [11:0] VIN [0:7] = '{12'h5a3, 12'h9c4, 12'h3e7,
    12'h800, 12'h000, 12'hfff, 12'h000, 12'h000};
  // Ratio diode input wanders per acquisition to exercise the sort
  localparam logic [11:0] NZ [0:7] = '{12'h310, 12'h000, 12'h340,
    12'h2f0, 12'h3ff, 12'h100, 12'h320, 12'h300};
  logic [2:0] k_ff = 3'h0;
  logic [11:0] vin;
  logic tgl_ff = 1'b0;
  always @(posedge CLK) tgl_ff <= ~tgl_ff;
  always @(posedge sample) if (mux_sel == 3'h4) k_ff <= k_ff + 3'h1;
  assign vin = (mux_sel == 3'h4) ? NZ[k_ff] : VIN[mux_sel];
  // Unselected input gives a toggling answer
  assign comp = (mux_sel == 3'h7) ? tgl_ff
    : (vin >= dac_code);
endmodule

// >>> testbench/touch_adc_conversion_control_tb_top.sv
`timescale 1ns/10ps
module touch_adc_conversion_control_tb_top;
  logic CLK, NRST, CMD_VALID, CMD_DRV_ONLY, CMD_MODE8, CMD_FILT_BYPASS;
  logic RESULT_READ, COMP_IN, BUSY, RESULT_VALID, RESULT_8BIT, SAMPLE;
  logic DRV_XP, DRV_XN, DRV_YP, DRV_YN;
  logic [2:0] CMD_CHAN, MUX_SEL;
  logic [1:0] REF_SEL;
  logic [11:0] RESULT, DAC_CODE;
  int error_cnt = 0;
  int tests_run = 0;
  // Channel, mode8, bypass, expected result
  logic [16:0] rows [0:8] = '{{3'h0, 2'h1, 12'h9c4},
    {3'h1, 2'h3, 12'h05a}, {3'h2, 2'h0, 12'h5a3}, {3'h3, 2'h2, 12'h03e},
    {3'h4, 2'h1, 12'h800}, {3'h5, 2'h3, 12'h000}, {3'h6, 2'h1, 12'hfff},
    {3'h6, 2'h3, 12'h0ff}, {3'h5, 2'h0, 12'h310}};
  tcc_ctrl u_dut (.CLK, .NRST, .CMD_VALID, .CMD_CHAN, .CMD_DRV_ONLY,
    .CMD_MODE8, .CMD_FILT_BYPASS, .RESULT_READ, .COMP_IN, .BUSY, .RESULT,
    .RESULT_VALID, .RESULT_8BIT, .MUX_SEL, .REF_SEL, .DRV_XP, .DRV_XN,
    .DRV_YP, .DRV_YN, .SAMPLE, .DAC_CODE);
  tcc_afe u_afe (.CLK, .mux_sel(MUX_SEL), .dac_code(DAC_CODE),
    .sample(SAMPLE), .comp(COMP_IN));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // ==========================================
  // Tasks
  task automatic chk_res(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t value %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [2:0] ch, input logic m8, input logic byp,
    input logic dro);
    @(negedge CLK);
    CMD_CHAN = ch;
    CMD_MODE8 = m8;
    CMD_FILT_BYPASS = byp;
    CMD_DRV_ONLY = dro;
    CMD_VALID = 1'b1;
    @(negedge CLK);
    CMD_VALID = 1'b0;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    @(negedge CLK);
    while (BUSY !== 1'b0 && n < 5000) begin
      @(negedge CLK);
      n++;
    end
    if (BUSY !== 1'b0) begin
      error_cnt++;
      $display("[FAIL] %0t busy stuck", $time);
    end
    @(negedge CLK);
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    end_of_test;
  end
  // ==========================================
  // Sequence
  initial begin
    {NRST, CMD_VALID, CMD_DRV_ONLY, CMD_MODE8} = 4'h0;
    {CMD_FILT_BYPASS, RESULT_READ, CMD_CHAN} = 5'h00;
    repeat (12) @(negedge CLK);
    NRST = 1'b1;
    chk_res({9'h000, MUX_SEL}, 12'h007);
    foreach (rows[i]) begin
      cmd(rows[i][16:14], rows[i][13], rows[i][12], 1'b0);
      wait_done;
      chk_res(RESULT, rows[i][11:0]);
      chk_bit(RESULT_8BIT, rows[i][13]);
      chk_bit(RESULT_VALID, 1'b1);
      RESULT_READ = 1'b1;
      @(negedge CLK);
      RESULT_READ = 1'b0;
      @(negedge CLK);
      chk_bit(RESULT_VALID, 1'b0);
      chk_res(RESULT, rows[i][11:0]);
    end
    cmd(3'h1, 1'b0, 1'b1, 1'b1);
    repeat (3) @(negedge CLK);
    chk_bit(BUSY, 1'b0);
    chk_bit(DRV_YP & DRV_YN, 1'b1);
    repeat (10) @(negedge CLK);
    cmd(3'h1, 1'b0, 1'b1, 1'b0);
    wait_done;
    chk_res(RESULT, 12'h5a3);
    cmd(3'h6, 1'b1, 1'b1, 1'b0);
    cmd(3'h0, 1'b0, 1'b1, 1'b0);
    wait_done;
    chk_res(RESULT, 12'h0ff);
    cmd(3'h0, 1'b0, 1'b0, 1'b0);
    repeat (40) @(negedge CLK);
    NRST = 1'b0;
    @(negedge CLK);
    chk_bit(BUSY | RESULT_VALID | DRV_XP, 1'b0);
    chk_res(RESULT, 12'h000);
    NRST = 1'b1;
    cmd(3'h4, 1'b1, 1'b0, 1'b0);
    wait_done;
    chk_res(RESULT, 12'h080);
    end_of_test;
  end
endmodule
